/* File: shared/ssp_pkg.sv */
// Purpose: Constants for the serial programming front end and power-down control
// Assumes: Control words are 24 bits, address field in the low four bits
// Notes:   Field positions follow the control word layouts
package ssp_pkg;
    localparam int          WORD_W        = 24;
    localparam int          ADDR_W        = 4;
    localparam int          NUM_WORDS     = 8;
    localparam int          IDX_W         = 3;
    // Word indices
    localparam logic [2:0]  IDX_MAIN_DIV  = 3'h0;
    localparam logic [2:0]  IDX_MAIN_REF  = 3'h1;
    localparam logic [2:0]  IDX_AUX_DIV   = 3'h2;
    localparam logic [2:0]  IDX_PUMP      = 3'h3;
    localparam logic [2:0]  IDX_MODE      = 3'h4;
    localparam logic [2:0]  IDX_EXT_FRAC  = 3'h5;
    localparam logic [2:0]  IDX_FASTLOCK  = 3'h6;
    localparam logic [2:0]  IDX_TEST      = 3'h7;
    // Field positions
    localparam int          PD_BIT        = 23;
    localparam int          AUTO_POWERUP_ON_WRITE_BIT      = 23;
    localparam int          N_MSB         = 23;
    localparam int          N_LSB         = 13;
    localparam int          FN_LO_MSB     = 12;
    localparam int          FN_LO_LSB     = 1;
    localparam int          REF_MSB       = 21;
    localparam int          REF_LSB       = 16;
    localparam int          FD_LO_MSB     = 15;
    localparam int          FD_LO_LSB     = 4;
    localparam int          AUXN_MSB      = 22;
    localparam int          AUXN_LSB      = 4;
    localparam int          ACC_MSB       = 23;
    localparam int          ACC_LSB       = 20;
    localparam int          CPG_MSB       = 19;
    localparam int          CPG_LSB       = 16;
    localparam int          AUXR_MSB      = 15;
    localparam int          AUXR_LSB      = 4;
    localparam int          DITHER_SEL_MSB      = 17;
    localparam int          DITHER_SEL_LSB      = 16;
    localparam int          FM_MSB        = 15;
    localparam int          FM_LSB        = 14;
    localparam int          FD_HI_MSB     = 23;
    localparam int          FD_HI_LSB     = 14;
    localparam int          FN_HI_MSB     = 13;
    localparam int          FN_HI_LSB     = 4;
    localparam int          CSR_MSB       = 23;
    localparam int          CSR_LSB       = 22;
    localparam int          CPF_MSB       = 21;
    localparam int          CPF_LSB       = 18;
    localparam int          TOC_MSB       = 17;
    localparam int          TOC_LSB       = 4;
    localparam int          TOC_W         = 14;
    // Field codes
    localparam logic [1:0]  FM_CODE_4TH   = 2'h0;
    localparam logic [1:0]  FM_CODE_2ND   = 2'h2;
    localparam logic [1:0]  FM_CODE_3RD   = 2'h3;
    localparam logic [2:0]  ORDER_2       = 3'h2;
    localparam logic [2:0]  ORDER_3       = 3'h3;
    localparam logic [2:0]  ORDER_4       = 3'h4;
    localparam logic [1:0]  DITHER_SEL_CODE_OFF = 2'h0;
    localparam logic [1:0]  DITHER_SEL_CODE_WK  = 2'h1;
    localparam logic [1:0]  DITHER_SEL_CODE_STR = 2'h2;
    localparam logic [1:0]  DITHER_SEL_LVL_OFF  = 2'h0;
    localparam logic [1:0]  DITHER_SEL_LVL_WEAK = 2'h1;
    localparam logic [1:0]  DITHER_SEL_LVL_STR  = 2'h2;
    // Reset values: third order, strong dither, 12-bit, fastlock off
    localparam logic [23:0] RST_WORD      = 24'h000000;
    localparam logic [23:0] RST_MODE      = 24'h22c009;
    typedef enum logic [1:0] {
        FL_IDLE = 2'b01,
        FL_RUN  = 2'b10
    } ssp_fl_state_t;
endpackage

/* File: src/ssp_shift_in.sv */
// Purpose: Serial shift register on the programming link clock
// Assumes: Data line is stable around each rising link clock edge
// Notes:   Contents are read by the core domain only after the load strobe rises
`timescale 1ns/100ps
module ssp_shift_in
    import ssp_pkg::*;
(
    // Link side
    input  wire logic              prog_clk,
    input  wire logic              rst_n,
    input  wire logic              prog_data,
    // Shifted word
    output logic [WORD_W-1:0]      shift_word_ff
);
    // Newest bit enters at the bottom so the last four bits land in the address field
    always_ff @(posedge prog_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_word_ff <= RST_WORD;
        end else begin
            shift_word_ff <= {shift_word_ff[WORD_W-2:0], prog_data};
        end
    end
endmodule

/* File: src/ssp_prog_ctl.sv */
// Contract
// - Enable pin low powers everything down at once, overriding all settings.
// - Enable high with both loop power-down bits zero powers up fully.
// - Enable high, a loop power-down bit of one powers that loop down.
// - Auto power-up set plus main divider write powers main loop up.
// - Words are 24 bits; bits 23..4 data, bits 3..0 address field; word 0 takes data down to bit 1, only bit 0 addressing it.
// - Host shifts MSB first; last four bits shifted form the address.
// - Rising load strobe copies the shift register into the addressed word.
// - Bit0 clear selects word 0; odd codes 3..15 select words 1..7.
// - Main divider write restarts lock and fastlock counters and arms auto power-up when set.
// - Modulator code 0 is fourth, 2 second, 3 third order.
// - Dither code 0 off, 1 weak, 2 strong.
//
// Purpose: Serial programming latch bank and power-down control
// Assumes: Link clock idles while the load strobe is high
// Notes:   Word capture relies on the shift register being static after the strobe
`timescale 1ns/100ps
module ssp_prog_ctl
    import ssp_pkg::*;
(
    // Core clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    // Programming link
    input  wire logic                prog_clk,
    input  wire logic                prog_data,
    input  wire logic                load_strobe,
    // Device enable pin
    input  wire logic                chip_enable,
    // Power state
    output logic                     main_loop_on_ff,
    output logic                     aux_loop_on_ff,
    // Main loop settings
    output logic [10:0]              main_divider_value_ff,
    output logic [21:0]              main_fraction_numerator_ff,
    output logic [21:0]              main_fraction_denominator_ff,
    output logic [5:0]               main_reference_divider_ff,
    output logic [3:0]               main_pump_gain_ff,
    output logic                     extended_fraction_ff,
    // Auxiliary loop settings
    output logic [18:0]              aux_divider_value_ff,
    output logic [11:0]              aux_reference_divider_ff,
    // Modulator controls
    output logic [2:0]               modulator_order_ff,
    output logic [1:0]               dither_level_ff,
    // Fastlock
    output logic [3:0]               fastlock_pump_gain_ff,
    output logic [1:0]               slip_reduction_factor_ff,
    output logic                     fastlock_active_ff,
    output logic [3:0]               active_pump_gain_ff,
    // Counter restart and write indication
    output logic                     lock_restart_ff,
    output logic [NUM_WORDS-1:0]     word_written_ff
);
    logic [WORD_W-1:0]          shift_word;
    logic [2:0]                 strobe_sync_ff;
    logic                       load_pulse;
    logic [ADDR_W-1:0]          addr_field;
    logic [IDX_W-1:0]           word_idx;
    logic                       addr_ok;
    logic [WORD_W-1:0]          word_ff [NUM_WORDS];
    logic [NUM_WORDS-1:0]       nxt_written;
    logic [1:0]                 en_sync_ff;
    logic                       power_rst_n;
    logic                       auto_up_ff;
    logic [1:0]                 fm_code;
    logic [1:0]                 dither_sel_code;
    logic [TOC_W-1:0]           toc_value;
    logic [TOC_W-1:0]           fl_count_ff;
    ssp_fl_state_t              fl_state_ff;
    ssp_fl_state_t              nxt_fl_state;
    logic [2:0]                 nxt_order;
    logic [1:0]                 nxt_dither;

    // Link domain front end
    ssp_shift_in u_shift (
        .prog_clk      (prog_clk),
        .rst_n         (rst_n),
        .prog_data     (prog_data),
        .shift_word_ff (shift_word)
    );

    // Strobe crossing: two flops, third flop only for edge detection
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_sync_ff <= 3'h0;
        end else begin
            strobe_sync_ff <= {strobe_sync_ff[1:0], load_strobe};
        end
    end

    // The shift word is static by the time the synchronized edge appears,
    // so a direct multi-bit capture is safe without a gray code
    assign load_pulse = strobe_sync_ff[1] & ~strobe_sync_ff[2];

    // Address decode of the low four bits
    assign addr_field = shift_word[ADDR_W-1:0];
    always_comb begin
        if (!addr_field[0]) begin
            word_idx = IDX_MAIN_DIV;
            addr_ok  = 1'b1;
        end else begin
            word_idx = addr_field[3:1];
            addr_ok  = (addr_field[3:1] != 3'h0);
        end
    end

    // Code 0001 maps to no word and is dropped
    always_comb begin
        nxt_written = '0;
        if (load_pulse && addr_ok) begin
            nxt_written[word_idx] = 1'b1;
        end
    end

    // Control word latches; only the addressed word changes
    generate
        for (genvar g = 0; g < NUM_WORDS; g++) begin : g_word
            localparam logic [WORD_W-1:0] RST_VAL = (g == int'(IDX_MODE)) ? RST_MODE : RST_WORD;
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    word_ff[g] <= RST_VAL;
                end else if (nxt_written[g]) begin
                    word_ff[g] <= shift_word;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            word_written_ff <= '0;
            lock_restart_ff <= 1'b0;
        end else begin
            word_written_ff <= nxt_written;
            lock_restart_ff <= nxt_written[IDX_MAIN_DIV];
        end
    end

    // Enable pin: low clears power flops at once, release is synchronized
    assign power_rst_n = rst_n & chip_enable;

    always_ff @(posedge core_clk or negedge power_rst_n) begin
        if (!power_rst_n) begin
            en_sync_ff <= 2'h0;
        end else begin
            en_sync_ff <= {en_sync_ff[0], 1'b1};
        end
    end

    // Auto power-up override: armed by a main divider write with the option set,
    // withdrawn when the main power-down bit is rewritten
    always_ff @(posedge core_clk or negedge power_rst_n) begin
        if (!power_rst_n) begin
            auto_up_ff <= 1'b0;
        end else if (nxt_written[IDX_MAIN_DIV] && word_ff[IDX_MODE][AUTO_POWERUP_ON_WRITE_BIT]) begin
            auto_up_ff <= 1'b1;
        end else if (nxt_written[IDX_MAIN_REF]) begin
            auto_up_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge power_rst_n) begin
        if (!power_rst_n) begin
            main_loop_on_ff <= 1'b0;
            aux_loop_on_ff  <= 1'b0;
        end else begin
            main_loop_on_ff <= en_sync_ff[1] &
                               (~word_ff[IDX_MAIN_REF][PD_BIT] | auto_up_ff);
            aux_loop_on_ff  <= en_sync_ff[1] & ~word_ff[IDX_AUX_DIV][PD_BIT];
        end
    end

    // Field extraction
    assign fm_code   = word_ff[IDX_MODE][FM_MSB:FM_LSB];
    assign dither_sel_code = word_ff[IDX_MODE][DITHER_SEL_MSB:DITHER_SEL_LSB];
    assign toc_value = word_ff[IDX_FASTLOCK][TOC_MSB:TOC_LSB];

    // Unlisted modulator code falls back to third order
    always_comb begin
        case (fm_code)
            FM_CODE_4TH: nxt_order = ORDER_4;
            FM_CODE_2ND: nxt_order = ORDER_2;
            FM_CODE_3RD: nxt_order = ORDER_3;
            default:     nxt_order = ORDER_3;
        endcase
    end

    // Unlisted dither code treated as strong
    always_comb begin
        case (dither_sel_code)
            DITHER_SEL_CODE_OFF: nxt_dither = DITHER_SEL_LVL_OFF;
            DITHER_SEL_CODE_WK:  nxt_dither = DITHER_SEL_LVL_WEAK;
            DITHER_SEL_CODE_STR: nxt_dither = DITHER_SEL_LVL_STR;
            default:       nxt_dither = DITHER_SEL_LVL_STR;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            modulator_order_ff <= ORDER_3;
            dither_level_ff    <= DITHER_SEL_LVL_STR;
        end else begin
            modulator_order_ff <= nxt_order;
            dither_level_ff    <= nxt_dither;
        end
    end

    // Main loop settings; the fraction joins extended and base parts
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            main_divider_value_ff        <= '0;
            main_fraction_numerator_ff   <= '0;
            main_fraction_denominator_ff <= '0;
            main_reference_divider_ff    <= '0;
            main_pump_gain_ff            <= '0;
            extended_fraction_ff         <= 1'b0;
        end else begin
            main_divider_value_ff        <= word_ff[IDX_MAIN_DIV][N_MSB:N_LSB];
            main_fraction_numerator_ff   <= {word_ff[IDX_EXT_FRAC][FN_HI_MSB:FN_HI_LSB],
                                             word_ff[IDX_MAIN_DIV][FN_LO_MSB:FN_LO_LSB]};
            main_fraction_denominator_ff <= {word_ff[IDX_EXT_FRAC][FD_HI_MSB:FD_HI_LSB],
                                             word_ff[IDX_MAIN_REF][FD_LO_MSB:FD_LO_LSB]};
            main_reference_divider_ff    <= word_ff[IDX_MAIN_REF][REF_MSB:REF_LSB];
            main_pump_gain_ff            <= word_ff[IDX_PUMP][CPG_MSB:CPG_LSB];
            extended_fraction_ff         <= |word_ff[IDX_PUMP][ACC_MSB:ACC_LSB];
        end
    end

    // Auxiliary loop settings
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_divider_value_ff     <= '0;
            aux_reference_divider_ff <= '0;
        end else begin
            aux_divider_value_ff     <= word_ff[IDX_AUX_DIV][AUXN_MSB:AUXN_LSB];
            aux_reference_divider_ff <= word_ff[IDX_PUMP][AUXR_MSB:AUXR_LSB];
        end
    end

    // Fastlock timer: restarted by every main divider write, runs off while
    // the timeout field is zero; counts core cycles as its time base
    always_comb begin
        case (fl_state_ff)
            FL_IDLE: begin
                if (nxt_written[IDX_MAIN_DIV] && toc_value != '0) begin
                    nxt_fl_state = FL_RUN;
                end else begin
                    nxt_fl_state = FL_IDLE;
                end
            end
            FL_RUN: begin
                if (nxt_written[IDX_MAIN_DIV]) begin
                    nxt_fl_state = (toc_value != '0) ? FL_RUN : FL_IDLE;
                end else if (fl_count_ff == TOC_W'(1)) begin
                    nxt_fl_state = FL_IDLE;
                end else begin
                    nxt_fl_state = FL_RUN;
                end
            end
            default: nxt_fl_state = FL_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fl_state_ff <= FL_IDLE;
        end else begin
            fl_state_ff <= nxt_fl_state;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fl_count_ff <= '0;
        end else if (nxt_written[IDX_MAIN_DIV]) begin
            fl_count_ff <= toc_value;
        end else if (fl_state_ff == FL_RUN) begin
            fl_count_ff <= fl_count_ff - TOC_W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fastlock_active_ff       <= 1'b0;
            active_pump_gain_ff      <= '0;
            fastlock_pump_gain_ff    <= '0;
            slip_reduction_factor_ff <= '0;
        end else begin
            fastlock_active_ff       <= (nxt_fl_state == FL_RUN);
            active_pump_gain_ff      <= (nxt_fl_state == FL_RUN) ?
                                        word_ff[IDX_FASTLOCK][CPF_MSB:CPF_LSB] :
                                        word_ff[IDX_PUMP][CPG_MSB:CPG_LSB];
            fastlock_pump_gain_ff    <= word_ff[IDX_FASTLOCK][CPF_MSB:CPF_LSB];
            slip_reduction_factor_ff <= word_ff[IDX_FASTLOCK][CSR_MSB:CSR_LSB];
        end
    end
endmodule

/* File: tb/ssp_prog_ctl_sva.sv */
// Purpose: Port assertions for the programming latch bank and power control
// Assumes: Core clock domain only; link activity judged by its effects
// Notes:   Pulse timing follows the two-flop strobe sync of the design
`timescale 1ns/100ps
module ssp_prog_ctl_sva
    import ssp_pkg::*;
(
    // Clock and reset
    input wire logic                 core_clk,
    input wire logic                 rst_n,
    // Pins
    input wire logic                 load_strobe,
    input wire logic                 chip_enable,
    // Observed outputs
    input wire logic                 main_loop_on_ff,
    input wire logic                 aux_loop_on_ff,
    input wire logic [10:0]          main_divider_value_ff,
    input wire logic [2:0]           modulator_order_ff,
    input wire logic                 lock_restart_ff,
    input wire logic [NUM_WORDS-1:0] word_written_ff
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire any_wr = |word_written_ff;

    a_enable_low_off: assert property (
        !chip_enable |-> !main_loop_on_ff && !aux_loop_on_ff) else $error("loop on, enable low");
    a_strobe_cause: assert property (
        any_wr |-> $past(load_strobe, 2) && !$past(load_strobe, 5)) else $error("write w/o strobe");
    a_pulse_one_cycle: assert property (
        any_wr |=> !any_wr) else $error("write pulse too long");
    a_written_onehot: assert property (
        any_wr |-> $onehot(word_written_ff)) else $error("write pulse not one-hot");
    a_restart_with_w0: assert property (
        lock_restart_ff == word_written_ff[0]) else $error("restart not tied to word 0");
    a_divider_after_w0: assert property (
        $changed(main_divider_value_ff) |-> $past(word_written_ff[0])) else $error("divider moved");
    a_order_after_w4: assert property (
        $changed(modulator_order_ff) |-> $past(word_written_ff[IDX_MODE])) else $error("order moved");
    a_main_fall_cause: assert property (
        $fell(main_loop_on_ff) && chip_enable |-> $past(word_written_ff[1]))
        else $error("main off early");

    c_word0: cover property (word_written_ff[0] && main_loop_on_ff);
    c_main_off: cover property ($fell(main_loop_on_ff) && chip_enable);
    c_enable_low: cover property (!chip_enable);
endmodule

bind ssp_prog_ctl ssp_prog_ctl_sva i_ssp_prog_ctl_sva (.core_clk(core_clk), .rst_n(rst_n),
    .load_strobe(load_strobe), .chip_enable(chip_enable), .main_loop_on_ff(main_loop_on_ff),
    .aux_loop_on_ff(aux_loop_on_ff), .main_divider_value_ff(main_divider_value_ff),
    .modulator_order_ff(modulator_order_ff), .lock_restart_ff(lock_restart_ff),
    .word_written_ff(word_written_ff));

/* File: tb/ssp_host_model.sv */
// Purpose: Host side of the three-wire programming link
// Assumes: Link clock stands still outside frames, 48 ns period
// Notes:   Released data line shows the inverse of the last bit
`timescale 1ns/100ps
module ssp_host_model (
    // Link pins
    output logic prog_clk,
    output logic prog_data,
    output logic load_strobe
);
    initial begin
        prog_clk    = 1'b0;
        prog_data   = 1'b0;
        load_strobe = 1'b0;
    end
    task automatic send(input logic [23:0] w);
        // Offset keeps the strobe edge clear of the core clock edge
        #8;
        for (int i = 23; i >= 0; i--) begin
            prog_data = w[i];
            #24 prog_clk = 1'b1;
            #24 prog_clk = 1'b0;
        end
        prog_data = ~prog_data;
        #10 load_strobe = 1'b1;
        // Clock stays idle long after the strobe so the word is static
        #48 load_strobe = 1'b0;
        #20;
    endtask
endmodule

/* File: tb/ssp_prog_ctl_tb.sv */
// Purpose: Self-checking bench for the programming latch bank
// Assumes: Host model paces the link at 48 ns per bit
// Notes:   Write pulses are caught by a monitor as they land while the load strobe is still high
`timescale 1ns/100ps
module ssp_prog_ctl_tb
    import ssp_pkg::*;
();
    logic        core_clk, rst_n, chip_enable, prog_clk, prog_data, load_strobe;
    logic        main_loop_on_ff, aux_loop_on_ff, lock_restart_ff, seen_rs;
    logic [10:0] main_divider_value_ff;
    logic [5:0]  main_reference_divider_ff;
    logic [2:0]  modulator_order_ff;
    logic [1:0]  dither_level_ff;
    logic [7:0]  word_written_ff, seen_ww;
    logic [21:0] main_fraction_numerator_ff, main_fraction_denominator_ff;
    logic [18:0] aux_divider_value_ff;
    logic [11:0] aux_reference_divider_ff;
    logic [3:0]  main_pump_gain_ff, fastlock_pump_gain_ff, active_pump_gain_ff, seen_gain;
    logic [1:0]  slip_reduction_factor_ff;
    logic        extended_fraction_ff, fastlock_active_ff;
    int          n_mismatch, n_checks, n_fl;

    ssp_host_model i_ssp_host_model (.prog_clk(prog_clk), .prog_data(prog_data),
        .load_strobe(load_strobe));
    ssp_prog_ctl i_ssp_prog_ctl (.core_clk(core_clk), .rst_n(rst_n), .prog_clk(prog_clk),
        .prog_data(prog_data), .load_strobe(load_strobe), .chip_enable(chip_enable),
        .main_loop_on_ff(main_loop_on_ff), .aux_loop_on_ff(aux_loop_on_ff),
        .main_divider_value_ff(main_divider_value_ff),
        .main_fraction_numerator_ff(main_fraction_numerator_ff),
        .main_fraction_denominator_ff(main_fraction_denominator_ff),
        .main_reference_divider_ff(main_reference_divider_ff),
        .main_pump_gain_ff(main_pump_gain_ff), .extended_fraction_ff(extended_fraction_ff),
        .aux_divider_value_ff(aux_divider_value_ff),
        .aux_reference_divider_ff(aux_reference_divider_ff),
        .modulator_order_ff(modulator_order_ff), .dither_level_ff(dither_level_ff),
        .fastlock_pump_gain_ff(fastlock_pump_gain_ff),
        .slip_reduction_factor_ff(slip_reduction_factor_ff),
        .fastlock_active_ff(fastlock_active_ff), .active_pump_gain_ff(active_pump_gain_ff),
        .lock_restart_ff(lock_restart_ff), .word_written_ff(word_written_ff));

    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (word_written_ff !== 8'h00) begin
            seen_ww <= word_written_ff;
            seen_rs <= lock_restart_ff;
        end
        if (fastlock_active_ff === 1'b1) begin
            n_fl      <= n_fl + 1;
            seen_gain <= active_pump_gain_ff;
        end
    end

    task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Index below zero means the word must be dropped
    task automatic wr(input logic [23:0] w, input int idx);
        int n;
        n = 0;
        seen_ww = 8'h00;
        seen_rs = 1'b0;
        i_ssp_host_model.send(w);
        while (seen_ww === 8'h00 && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        if (idx >= 0 && seen_ww === 8'h00) begin
            n_mismatch++;
            finish_test;
        end
        repeat (2) @(posedge core_clk);
        #1;
        chk("written", seen_ww, (idx < 0) ? 8'h00 : 8'h01 << idx);
        chk("restart", seen_rs, idx == 0);
    endtask

    task t_reset;
        repeat (4) @(posedge core_clk);
        #1;
        chk("order", modulator_order_ff, ORDER_3);
        chk("dither", dither_level_ff, DITHER_SEL_LVL_STR);
        chk("main_on", main_loop_on_ff, 1'b1);
        chk("aux_on", aux_loop_on_ff, 1'b1);
    endtask

    task t_decode;
        for (int i = 1; i < NUM_WORDS; i++) wr({20'h00000, 3'(i), 1'b1}, i);
        wr(24'h000001, -1);
        wr(24'ha5e00e, 0);
        chk("divider", main_divider_value_ff, 11'h52f);
    endtask

    task t_modes;
        logic [1:0] fm [4];
        logic [2:0] ord [4];
        logic [1:0] lvl [4];
        fm  = '{FM_CODE_4TH, FM_CODE_2ND, FM_CODE_3RD, 2'h1};
        ord = '{ORDER_4, ORDER_2, ORDER_3, ORDER_3};
        lvl = '{DITHER_SEL_LVL_OFF, DITHER_SEL_LVL_WEAK, DITHER_SEL_LVL_STR, DITHER_SEL_LVL_STR};
        for (int i = 0; i < 4; i++) begin
            wr({6'h00, 2'(i), fm[i], 14'h0009}, 4);
            chk("order", modulator_order_ff, ord[i]);
            chk("dither", dither_level_ff, lvl[i]);
        end
    endtask

    task t_fields;
        wr(24'h151237, 3);
        chk("pump_gain", main_pump_gain_ff, 4'h5);
        chk("aux_ref", aux_reference_divider_ff, 12'h123);
        chk("ext_frac", extended_fraction_ff, 1'b1);
        wr(24'h2abcd5, 2);
        chk("aux_div", aux_divider_value_ff, 19'h2abcd);
        chk("aux_on", aux_loop_on_ff, 1'b1);
        wr(24'hf06a5b, 5);
        wr(24'hb0006d, 6);
        chk("slip", slip_reduction_factor_ff, 2'h2);
        chk("fl_gain", fastlock_pump_gain_ff, 4'hc);
        chk("fl_idle", fastlock_active_ff, 1'b0);
        n_fl = 0;
        seen_gain = 4'h0;
        wr(24'h247356, 0);
        chk("divider", main_divider_value_ff, 11'h123);
        chk("frac_num", main_fraction_numerator_ff, 22'h2a59ab);
        chk("frac_den", main_fraction_denominator_ff, 22'h3c1000);
        chk("fl_cycles", n_fl, 24'd6);
        chk("fl_pump", seen_gain, 4'hc);
        chk("pump_back", active_pump_gain_ff, 4'h5);
    endtask

    task t_power;
        wr(24'h800003, 1);
        chk("main_off", main_loop_on_ff, 1'b0);
        chk("aux_kept", aux_loop_on_ff, 1'b1);
        wr(24'h800005, 2);
        chk("aux_off", aux_loop_on_ff, 1'b0);
        wr(24'h800009, 4);
        wr(24'h00000e, 0);
        chk("auto_up", main_loop_on_ff, 1'b1);
        @(posedge core_clk);
        chip_enable <= 1'b0;
        #1;
        chk("ce_main", main_loop_on_ff, 1'b0);
        chk("ce_aux", aux_loop_on_ff, 1'b0);
        repeat (3) @(posedge core_clk);
        chip_enable <= 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        chk("pd_held", main_loop_on_ff, 1'b0);
        // Word 5 left alone: extended fraction not used here
        wr(24'h2a0003, 1);
        wr(24'h000005, 2);
        wr(24'h000000, 0);
        chk("main_up", main_loop_on_ff, 1'b1);
        chk("aux_up", aux_loop_on_ff, 1'b1);
        chk("ref_kept", main_reference_divider_ff, 6'h2a);
    endtask

    initial begin
        core_clk    = 1'b0;
        rst_n       = 1'b0;
        chip_enable = 1'b1;
        n_mismatch  = 0;
        n_checks    = 0;
        seen_ww     = 8'h00;
        seen_rs     = 1'b0;
        n_fl        = 0;
        seen_gain   = 4'h0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset;
        t_decode;
        t_modes;
        t_power;
        t_fields;
        // Mid-run reset must bring back the mode word defaults, both loops on and a zero main divider
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset;
        chk("div_rst", main_divider_value_ff, 11'h000);
        finish_test;
    end
endmodule
